// [logic/acs_pkg.sv]
// Purpose: Shared constants for the converter sequencer
// Assumes: 100 MHz system clock, one clock domain
// Notes: Mode and channel registers are written as plain port strobes
//
// Function
// (R1) After reset, channel select picks one of eight analog inputs.
// (R2) Only a software mode write starts a conversion.
// (R3) Writing start bit 7 as one converts the selected channel.
// (R4) On completion, store the result and pulse the done request together.
// (R5) Each finished conversion starts the next, until the mode is rewritten.
// (R6) Mode write with start set aborts and restarts with new settings.
// (R7) Mode write with start clear halts conversion at once.
// (R8) Standby stops the converter.
// (R9) Result read colliding with update returns old value, update follows.
// (R10) Mode or channel write colliding with update wins; no store, no request.
// (R11) Without settled reference, first result after start is marked undefined.
// (R12) Software waits 14 us after reference enable, or drops first result.
// (R13) About one tenth of conversion time samples the input.
// (R14) Mode writes never clear the done flag.
// (R15) After channel change, flag and result may still be the old channel's.
// (R16) Software clears the done flag before restarting.
// (R17) Software reads results while running, or stops before next completion.
// (R18) Software avoids digital port reads on a selected analog pin.
// (R19) Mode bit 0 is the reference enable bit.
// (R20) Successive approximation from MSB to bit 0, one bit per stage.
// (R21) Reset clears the result register to zero.
// (R22) Software picks a conversion time of at least 14 us; the sequencer fixes it at 142 clocks, 1.42 us.
// (R23) Done request is one-cycle pulse setting a sticky flag.
package acs_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned START_BIT = 7;
  localparam int unsigned REF_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam int unsigned REF_SETTLE_US = 14;
  localparam int unsigned REF_SETTLE_CYC = REF_SETTLE_US * CLK_MHZ;
  localparam logic [10:0] REF_SETTLE_CNT = 11'(REF_SETTLE_CYC);
  // Conversion time selection, 142 system clocks per conversion (144 before step rounding)
  localparam int unsigned CONV_CYC = 144;
  localparam int unsigned SAMPLE_CYC = CONV_CYC / 10;
  localparam logic [7:0] SAMPLE_CNT = 8'(SAMPLE_CYC);
  localparam int unsigned STEP_CYC = (CONV_CYC - SAMPLE_CYC) / 8;
  localparam logic [7:0] STEP_CNT = 8'(STEP_CYC);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } acs_state_t;
endpackage

// [logic/acs_ref_timer.sv]
// Purpose: Tracks whether the reference has settled since being enabled
// Assumes: Enable is a level from the mode register
// Notes: Settled drops as soon as enable drops
`timescale 1ns/10ps
module acs_ref_timer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ref_en,
  output logic settled
);
  typedef struct packed {
    logic [10:0] cnt;
    logic done;
  } acs_rt_t;
  acs_rt_t st_ff, nxt_st;

  // ==========================================
  // Settle counter
  always_comb begin
    nxt_st = st_ff;
    if (!ref_en) begin
      nxt_st.cnt = 11'h000;
      nxt_st.done = 1'b0;
    end else if (st_ff.cnt < acs_pkg::REF_SETTLE_CNT - 11'h001) begin
      nxt_st.cnt = st_ff.cnt + 11'h001;
    end else begin
      nxt_st.done = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign settled = st_ff.done & ref_en;

  settle_time_a: assert property (@(posedge clk) disable iff (!arst_n) // R11
    $rose(st_ff.done) |-> $past(ref_en, 1))
    else $error("Reference settled without enable");
endmodule

// [logic/acs_sar_step.sv]
// Purpose: One successive approximation decision on the trial register
// Assumes: Comparator answer refers to the trial code currently presented
// Notes: Pure combinational; bit index counts down from 7
`timescale 1ns/10ps
module acs_sar_step (
  input wire logic [7:0] approx_in,
  input wire logic [2:0] bit_idx,
  input wire logic cmp_high,
  output logic [7:0] approx_out,
  output logic [7:0] trial_code
);
  // ==========================================
  // Keep or drop the tested bit, then set the next one
  always_comb begin
    approx_out = approx_in;
    approx_out[bit_idx] = cmp_high; // R20
    trial_code = approx_out;
    if (bit_idx != 3'h0) begin
      trial_code[bit_idx - 3'h1] = 1'b1; // R20
    end
  end
endmodule

// [logic/acs_sequencer.sv]
// Purpose: Control of an 8-bit successive approximation converter
// Assumes: Mode and channel writes arrive as one-cycle strobes with data
// Notes: Comparator is external; trial code drives the resistor tap
`timescale 1ns/10ps
module acs_sequencer (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic MODE_WR,
  input wire logic [7:0] MODE_WDATA,
  input wire logic CHAN_WR,
  input wire logic [2:0] CHAN_WDATA,
  input wire logic RESULT_RD,
  input wire logic FLAG_CLR,
  input wire logic STANDBY,
  input wire logic CMP_HIGH,
  output logic [7:0] CONV_MODE_REG,
  output logic [2:0] CHANNEL_SELECT_REG,
  output logic [7:0] CONV_RESULT_REG,
  output logic [7:0] RESULT_RDATA,
  output logic RESULT_UNDEF,
  output logic CONV_DONE_IRQ,
  output logic CONV_DONE_FLAG,
  output logic [7:0] ANALOG_INPUT_SEL,
  output logic SAMPLE_EN,
  output logic [7:0] TRIAL_CODE,
  output logic REF_ON,
  output logic BUSY
);
  typedef struct packed {
    acs_pkg::acs_state_t state;
    logic [7:0] mode;
    logic [2:0] chan;
    logic [7:0] result;
    logic [7:0] rdata;
    logic undef;
    logic first;
    logic [7:0] approx;
    logic [7:0] trial;
    logic [2:0] bit_idx;
    logic [7:0] cnt;
    logic irq;
    logic flag;
    logic pend;
    logic [7:0] pend_val;
    logic pend_undef;
    logic [7:0] samp_run;
    logic [8:0] quiet;
  } acs_seq_t;

  acs_seq_t st_ff, nxt_st;
  logic ref_settled;
  logic [7:0] step_approx;
  logic [7:0] step_trial;
  logic reg_write;
  logic finish;

  // ==========================================
  // Reference settle tracking
  acs_ref_timer u_ref (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .ref_en(st_ff.mode[acs_pkg::REF_BIT]),
    .settled(ref_settled)
  );

  // ==========================================
  // Bit decision
  acs_sar_step u_step (
    .approx_in(st_ff.trial),
    .bit_idx(st_ff.bit_idx),
    .cmp_high(CMP_HIGH),
    .approx_out(step_approx),
    .trial_code(step_trial)
  );

  assign reg_write = MODE_WR | CHAN_WR;
  assign finish = (st_ff.state == acs_pkg::ST_CONVERT) && (st_ff.cnt == 8'h00)
                  && (st_ff.bit_idx == 3'h0);

  // ==========================================
  // Sequencer, registers and result handling
  always_comb begin
    nxt_st = st_ff;
    nxt_st.irq = 1'b0;
    // Read serves stored value; a pending update lands afterwards
    if (RESULT_RD) begin
      nxt_st.rdata = st_ff.result; // R9
    end
    if (st_ff.pend && !RESULT_RD) begin
      nxt_st.result = st_ff.pend_val; // R9
      nxt_st.undef = st_ff.pend_undef;
      nxt_st.pend = 1'b0;
    end
    // Software clear; flag set below wins when both coincide
    if (FLAG_CLR) begin
      nxt_st.flag = 1'b0; // R16
    end
    if (CHAN_WR) begin
      nxt_st.chan = CHAN_WDATA; // R1 R15
    end
    if (MODE_WR) begin
      nxt_st.mode = MODE_WDATA; // R19
    end
    case (st_ff.state)
      acs_pkg::ST_IDLE: begin
        if (MODE_WR && MODE_WDATA[acs_pkg::START_BIT] && !STANDBY) begin
          nxt_st.state = acs_pkg::ST_SAMPLE; // R2 R3
          nxt_st.cnt = acs_pkg::SAMPLE_CNT - 8'h01;
          nxt_st.first = !(MODE_WDATA[acs_pkg::REF_BIT] && ref_settled); // R11
        end
      end
      acs_pkg::ST_SAMPLE: begin
        if (st_ff.cnt != 8'h00) begin
          nxt_st.cnt = st_ff.cnt - 8'h01; // R13
        end else begin
          nxt_st.state = acs_pkg::ST_CONVERT;
          nxt_st.bit_idx = 3'h7;
          nxt_st.trial = 8'h80; // R20
          nxt_st.cnt = acs_pkg::STEP_CNT - 8'h01;
        end
      end
      acs_pkg::ST_CONVERT: begin
        if (st_ff.cnt != 8'h00) begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end else begin
          nxt_st.trial = step_trial; // R20
          nxt_st.approx = step_approx;
          nxt_st.cnt = acs_pkg::STEP_CNT - 8'h01;
          if (st_ff.bit_idx != 3'h0) begin
            nxt_st.bit_idx = st_ff.bit_idx - 3'h1;
          end else begin
            // Completion; a colliding register write suppresses it
            if (!reg_write) begin
              nxt_st.irq = 1'b1; // R4 R23
              if (RESULT_RD) begin
                nxt_st.pend = 1'b1; // R9
                nxt_st.pend_val = step_approx;
                nxt_st.pend_undef = st_ff.first;
              end else begin
                nxt_st.result = step_approx; // R4
                nxt_st.undef = st_ff.first; // R11
              end
            end
            nxt_st.first = 1'b0;
            nxt_st.state = acs_pkg::ST_SAMPLE; // R5
            nxt_st.cnt = acs_pkg::SAMPLE_CNT - 8'h01;
          end
        end
      end
      default: begin
        nxt_st.state = acs_pkg::ST_IDLE;
      end
    endcase
    // Register writes while running abort or stop the conversion
    if (st_ff.state != acs_pkg::ST_IDLE && reg_write) begin
      if (MODE_WR && !MODE_WDATA[acs_pkg::START_BIT]) begin
        nxt_st.state = acs_pkg::ST_IDLE; // R7
      end else if (nxt_st.mode[acs_pkg::START_BIT]) begin
        nxt_st.state = acs_pkg::ST_SAMPLE; // R6
        nxt_st.cnt = acs_pkg::SAMPLE_CNT - 8'h01;
        if (MODE_WR) begin
          nxt_st.first = !(MODE_WDATA[acs_pkg::REF_BIT] && ref_settled); // R11
        end
      end
    end
    if (STANDBY) begin
      nxt_st.state = acs_pkg::ST_IDLE; // R8
    end
    if (nxt_st.irq) begin
      nxt_st.flag = 1'b1; // R23 R14
    end
    // Sampling window length and quiet time, kept for the checks below
    if (st_ff.state != acs_pkg::ST_SAMPLE) begin
      nxt_st.samp_run = 8'h00;
    end else if (st_ff.samp_run != 8'hff) begin
      nxt_st.samp_run = st_ff.samp_run + 8'h01;
    end
    if (reg_write || st_ff.state == acs_pkg::ST_IDLE) begin
      nxt_st.quiet = 9'h000;
    end else if (st_ff.quiet != 9'h1ff) begin
      nxt_st.quiet = st_ff.quiet + 9'h001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff <= '0;
      st_ff.state <= acs_pkg::ST_IDLE;
      st_ff.mode <= acs_pkg::MODE_RESET;
      st_ff.chan <= acs_pkg::CHAN_RESET; // R1
      st_ff.result <= acs_pkg::RESULT_RESET; // R21
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================
  // Outputs
  assign CONV_MODE_REG = st_ff.mode;
  assign CHANNEL_SELECT_REG = st_ff.chan;
  assign CONV_RESULT_REG = st_ff.result;
  assign RESULT_RDATA = st_ff.rdata;
  assign RESULT_UNDEF = st_ff.undef;
  assign CONV_DONE_IRQ = st_ff.irq;
  assign CONV_DONE_FLAG = st_ff.flag;
  assign ANALOG_INPUT_SEL = 8'h01 << st_ff.chan; // R1
  assign SAMPLE_EN = (st_ff.state == acs_pkg::ST_SAMPLE); // R13
  assign TRIAL_CODE = st_ff.trial;
  assign REF_ON = st_ff.mode[acs_pkg::REF_BIT]; // R19
  assign BUSY = (st_ff.state != acs_pkg::ST_IDLE);

  // ==========================================
  // Checks
  start_by_sw_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R2
    $rose(BUSY) |-> $past(MODE_WR) && $past(MODE_WDATA[7]))
    else $error("Conversion began without a mode write");
  start_seq_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R3
    (!BUSY && MODE_WR && MODE_WDATA[7] && !STANDBY) |=> SAMPLE_EN)
    else $error("Start bit did not begin sampling");
  done_store_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R4
    (finish && !reg_write && !RESULT_RD) |=> CONV_DONE_IRQ
      && CONV_RESULT_REG == $past(step_approx))
    else $error("Result and request not together");
  auto_repeat_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R5
    (finish && !reg_write && !STANDBY) |=> SAMPLE_EN)
    else $error("Next conversion did not start");
  stop_now_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R7
    (MODE_WR && !MODE_WDATA[7]) |=> !BUSY)
    else $error("Stop write did not halt");
  standby_stop_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R8
    STANDBY |=> !BUSY)
    else $error("Converter ran in standby");
  read_first_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R9
    (finish && !reg_write && RESULT_RD) |=> RESULT_RDATA == $past(CONV_RESULT_REG)
      ##1 CONV_RESULT_REG == $past(step_approx, 2))
    else $error("Read collision order wrong");
  write_wins_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R10
    (finish && reg_write && !st_ff.pend) |=> !CONV_DONE_IRQ && $stable(CONV_RESULT_REG))
    else $error("Write did not win collision");
  flag_keep_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R14 R23
    (CONV_DONE_FLAG && !FLAG_CLR) |=> CONV_DONE_FLAG)
    else $error("Flag lost without clear");
  irq_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R23
    CONV_DONE_IRQ |-> CONV_DONE_FLAG ##1 !CONV_DONE_IRQ)
    else $error("Request not a single pulse");
  sample_len_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R13
    $rose(SAMPLE_EN) && !STANDBY && !reg_write |-> SAMPLE_EN [*8])
    else $error("Sampling window too short");

  // ==========================================
  // Checks on register writes, timing and result marking
  chan_write_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R1
    CHAN_WR |=> CHANNEL_SELECT_REG == $past(CHAN_WDATA))
    else $error("Channel write not taken");
  sel_onehot_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R1
    $onehot(ANALOG_INPUT_SEL))
    else $error("Input select not one-hot");
  mode_write_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R19
    MODE_WR |=> CONV_MODE_REG == $past(MODE_WDATA) && REF_ON == $past(MODE_WDATA[0]))
    else $error("Mode write not taken");
  restart_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R6
    (BUSY && MODE_WR && MODE_WDATA[7] && !STANDBY) |=> SAMPLE_EN
      && st_ff.cnt == acs_pkg::SAMPLE_CNT - 8'h01)
    else $error("Restart did not begin a fresh window");
  first_mark_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R11
    (!BUSY && MODE_WR && MODE_WDATA[7] && !STANDBY && !REF_ON) |=> st_ff.first)
    else $error("Unsettled start not marked");
  mode_keep_flag_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R14
    (CONV_DONE_FLAG && MODE_WR && !FLAG_CLR) |=> CONV_DONE_FLAG)
    else $error("Mode write cleared the flag");
  old_result_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R10 R15
    (reg_write && !finish && !st_ff.pend) |=> $stable(CONV_RESULT_REG))
    else $error("Register write disturbed the result");
  trial_start_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R20
    (st_ff.state == acs_pkg::ST_SAMPLE && st_ff.cnt == 8'h00 && !reg_write && !STANDBY)
      |=> TRIAL_CODE == 8'h80)
    else $error("Approximation did not start at the top bit");
  approx_track_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R20
    (finish && !reg_write && !RESULT_RD) |=> CONV_RESULT_REG == st_ff.approx)
    else $error("Stored result differs from the approximation");
  sample_min_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R13
    $fell(SAMPLE_EN) && BUSY |-> st_ff.samp_run >= acs_pkg::SAMPLE_CNT)
    else $error("Sampling window shorter than its count");
  done_time_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R4 R5
    st_ff.quiet == 9'(acs_pkg::SAMPLE_CYC + 8 * acs_pkg::STEP_CYC) |-> CONV_DONE_IRQ)
    else $error("Completion late");
  done_early_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // R5
    CONV_DONE_IRQ |-> st_ff.quiet >= 9'(acs_pkg::SAMPLE_CYC + 8 * acs_pkg::STEP_CYC))
    else $error("Completion early");
  reset_result_a: assert property (@(posedge CLK_SYS) // R21
    !ARST_N |-> CONV_RESULT_REG == acs_pkg::RESULT_RESET)
    else $error("Result not cleared in reset");

  restart_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    BUSY && MODE_WR && MODE_WDATA[7]);
  two_done_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CONV_DONE_IRQ ##[1:300] CONV_DONE_IRQ);
  read_clash_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    finish && RESULT_RD);
  write_clash_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    finish && CHAN_WR);
  undef_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CONV_DONE_IRQ && RESULT_UNDEF);
endmodule

// [dv/acs_analog_src.sv]
// Purpose: Model of the eight analog sources and the sample-and-hold comparator
// Assumes: One-hot input select, sampling while sample enable is high
// Notes: Channel n sits at code 8'h1b + 8'h1d * n
`timescale 1ns/10ps
module acs_analog_src (
  input wire logic clk,
  input wire logic [7:0] input_sel,
  input wire logic sample_en,
  input wire logic [7:0] trial_code,
  output logic cmp_high
);
  logic [7:0] held_ff = 8'h00;
  // ==========================================
  // Sample and hold
  // Pins stay analog only and are never read as a digital port
  always @(posedge clk) begin
    if (sample_en) begin
      for (int i = 0; i < 8; i++) begin
        if (input_sel[i]) begin
          held_ff <= 8'h1b + 8'h1d * 8'(i);
        end
      end
    end
  end
  // Comparator answer against the tap under test
  assign cmp_high = (held_ff >= trial_code);
endmodule

// [dv/acs_sequencer_test.sv]
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Inputs driven at the falling edge, strobes one cycle long
// Notes: Latencies counted in falling edges after the strobe
`timescale 1ns/10ps
module acs_sequencer_test;
  logic clk_sys, arst_n, mode_wr, chan_wr, result_rd, flag_clr, standby, cmp_high;
  logic [7:0] mode_wdata;
  logic [2:0] chan_wdata;
  logic [7:0] mode_q, result_q, rdata, in_sel, trial;
  logic [2:0] chan_q;
  logic undef, irq, flag, samp, ref_on, busy;
  int n_mismatch = 0;
  int num_checks = 0;
  int k, s;

  acs_sequencer uut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .MODE_WR(mode_wr),
    .MODE_WDATA(mode_wdata), .CHAN_WR(chan_wr), .CHAN_WDATA(chan_wdata),
    .RESULT_RD(result_rd), .FLAG_CLR(flag_clr), .STANDBY(standby), .CMP_HIGH(cmp_high),
    .CONV_MODE_REG(mode_q), .CHANNEL_SELECT_REG(chan_q), .CONV_RESULT_REG(result_q),
    .RESULT_RDATA(rdata), .RESULT_UNDEF(undef), .CONV_DONE_IRQ(irq),
    .CONV_DONE_FLAG(flag), .ANALOG_INPUT_SEL(in_sel), .SAMPLE_EN(samp),
    .TRIAL_CODE(trial), .REF_ON(ref_on), .BUSY(busy));
  acs_analog_src src (.clk(clk_sys), .input_sel(in_sel), .sample_en(samp),
    .trial_code(trial), .cmp_high(cmp_high));

  // ==========================================
  // Helpers
  function automatic logic [7:0] lvl(input int c);
    return 8'h1b + 8'h1d * 8'(c);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Strobes: raised at one falling edge, dropped at the next
  task automatic wr_mode(input logic [7:0] d);
    mode_wdata = d;
    mode_wr = 1'b1;
    cyc(1);
    mode_wr = 1'b0;
  endtask
  task automatic wr_chan(input logic [2:0] c);
    chan_wdata = c;
    chan_wr = 1'b1;
    cyc(1);
    chan_wr = 1'b0;
  endtask
  task automatic clr_flag;
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
  endtask
  // Bounded wait for the done pulse, counting sampling cycles on the way
  task automatic wait_irq(input int lim, output int n, output int sc);
    n = 0;
    sc = 0;
    while (n < lim && irq !== 1'b1) begin
      if (samp === 1'b1) sc++;
      cyc(1);
      n++;
    end
  endtask
  task automatic expect_irq(output int n, output int sc);
    wait_irq(400, n, sc);
    if (n == 400) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: no completion pulse", $time);
      wrap_up();
    end
  endtask

  // ==========================================
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Main sequence
  initial begin
    {arst_n, mode_wr, chan_wr, result_rd, flag_clr, standby} = 6'h00;
    mode_wdata = 8'h00;
    chan_wdata = 3'h0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    cyc(20);
    chk(result_q, 8'h00, "result after reset");
    chk(in_sel, 8'h01, "select after reset");
    chk(8'(busy), 8'h00, "idle without start");
    $display("test reset done");
    // Every channel: first result, pulse, flag, then the automatic repeat
    for (int c = 0; c < 8; c++) begin
      wr_chan(3'(c));
      cyc(1);
      wr_mode(8'h81);
      expect_irq(k, s);
      chk(8'(k), 8'(acs_pkg::SAMPLE_CYC + 8 * acs_pkg::STEP_CYC), "first latency");
      chk(8'(s), acs_pkg::SAMPLE_CNT, "sampling cycles");
      chk(result_q, lvl(c), "result code");
      chk(8'({irq, flag}), 8'h03, "pulse with flag");
      chk(8'(undef), 8'h01, "first result marked");
      chk(in_sel, 8'h01 << c, "one-hot select");
      cyc(1);
      chk(8'({irq, flag}), 8'h01, "pulse one cycle, flag held");
      expect_irq(k, s);
      chk(8'(k), 8'h8d, "repeat period");
      chk(8'(undef), 8'h00, "second result valid");
      clr_flag();
      wr_mode(8'h00);
    end
    $display("test channels done");
    // Settled reference: first result already valid
    wr_mode(8'h01);
    cyc(1500);
    wr_mode(8'h81);
    expect_irq(k, s);
    chk(8'(undef), 8'h00, "settled first result");
    // Restart mid-conversion keeps the flag and restarts timing
    cyc(100);
    wr_mode(8'h81);
    chk(8'(flag), 8'h01, "flag kept by mode write");
    expect_irq(k, s);
    chk(8'(k), 8'(acs_pkg::SAMPLE_CYC + 8 * acs_pkg::STEP_CYC), "restart latency");
    // Stop mid-conversion
    clr_flag();
    cyc(50);
    wr_mode(8'h01);
    chk(8'(busy), 8'h00, "stopped at once");
    wait_irq(300, k, s);
    chk(8'(k == 300), 8'h01, "no pulse after stop");
    $display("test restart and stop done");
    // Read colliding with completion, read made while running
    wr_chan(3'h2);
    cyc(1);
    wr_mode(8'h81);
    cyc(141);
    result_rd = 1'b1;
    cyc(1);
    result_rd = 1'b0;
    chk(rdata, lvl(7), "read gets old value");
    chk(result_q, lvl(7), "update after read");
    chk(8'(irq), 8'h01, "pulse on read collision");
    cyc(1);
    chk(result_q, lvl(2), "new value stored");
    clr_flag();
    // Channel write colliding with the next completion
    cyc(139);
    wr_chan(3'h4);
    chk(8'({irq, flag}), 8'h00, "no pulse on write collision");
    chk(result_q, lvl(2), "result kept on write collision");
    expect_irq(k, s);
    chk(result_q, lvl(4), "new channel result");
    $display("test collisions done");
    // Standby stops a running conversion and blocks starts
    cyc(20);
    standby = 1'b1;
    cyc(2);
    chk(8'(busy), 8'h00, "standby stops");
    wr_mode(8'h81);
    wait_irq(300, k, s);
    chk(8'(k == 300), 8'h01, "no pulse in standby");
    wr_mode(8'h00);
    standby = 1'b0;
    $display("test standby done");
    wrap_up();
  end
endmodule
